/* File: design/adcsq_pkg.sv */
// package: register map, field layout, modes and timing of the converter sequencer
// How it works
// (RL1) divider select 000/4 001/2 010/1 100/12 101/6 110/3 forms the conversion clock
// (RL2) reserved codes 011 and 111 give 1 and 3; divider latched only between conversions
// (RL3) successive approximation, 10-bit code, or selectable 8-bit resolution
// (RL4) without sample-and-hold: 49 clocks at 8 bits, 59 at 10 bits
// (RL5) with sample-and-hold: 28 clocks at 8 bits, 33 at 10 bits
// (RL6) one-shot, repeat, single sweep, repeat sweeps 0/1, simultaneous, delayed trigger 0/1
// (RL7) result lands in result register of converted channel index 0..7, any group
// (RL8) ref_connect at 0 disconnects the reference; software clears it when unused
// (RL9) software sets analogue and trigger pins to input before use
// (RL10) software keeps conversion clock within 250kHz/1MHz and 10 MHz
// (RL11) software sets both timer trigger enables before delayed trigger mode 0
// (RL12) timer2_special_ctrl writes only while protect_write_en is 1
// (RL13) software trigger starts on start bit; hardware trigger on falling edge afterwards
// (RL14) one-shot stops at completion with interrupt, clears start bit if software triggered
// (RL15) repeat mode converts continuously without interrupt until start bit cleared
// (RL16) software does not rewrite conv_ctrl_first during a conversion
package adcsq_pkg;

    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_TRIG = 8'h08;
    localparam logic [7:0] ADDR_PROT = 8'h0c;
    localparam logic [7:0] ADDR_T2SC = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_RES0 = 8'h20;
    localparam logic [7:0] ADDR_RES7 = 8'h3c;

    // conv_ctrl_first fields
    localparam int C0_MODE = 0;
    localparam int C0_CHAN = 3;
    localparam int C0_TRIG = 6;
    localparam int C0_START = 7;
    localparam int C0_SWEEP = 8;
    // second control word, protect and status bit fields
    localparam int C1_DIV = 0;
    localparam int C1_RES10 = 3;
    localparam int C1_SH = 4;
    localparam int C1_REF = 5;
    localparam int C1_GROUP = 6;
    localparam int PROT_BIT = 1;
    localparam int ST_DONE = 0;
    localparam int ST_TRIG = 1;
    localparam int ST_BUSY = 8;

    localparam logic [5:0] CYC_8_NOSH = 6'd49;
    localparam logic [5:0] CYC_10_NOSH = 6'd59;
    localparam logic [5:0] CYC_8_SH = 6'd28;
    localparam logic [5:0] CYC_10_SH = 6'd33;
    localparam logic [3:0] MSB_IDX = 4'd9;
    localparam logic [4:0] RST_CTRL1 = 5'h00;

    typedef enum logic [2:0] {
        ADCSQ_ONE_SHOT, ADCSQ_REPEAT, ADCSQ_SWEEP, ADCSQ_REP_SWEEP0,
        ADCSQ_REP_SWEEP1, ADCSQ_SIMUL, ADCSQ_DLY_TRIG0, ADCSQ_DLY_TRIG1
    } adcsq_mode_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } adcsq_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } adcsq_apb_rsp_t;

    typedef struct packed {
        logic sample_en;
        logic [9:0] dac_code;
        logic [1:0] group;
        logic [2:0] channel;
        logic ref_connect;
    } adcsq_afe_t;

    function automatic logic [3:0] adcsq_div(input logic [2:0] sel);
        case (sel)
            3'h0: adcsq_div = 4'd4;
            3'h1: adcsq_div = 4'd2;
            3'h4: adcsq_div = 4'd12;
            3'h5: adcsq_div = 4'd6;
            3'h6, 3'h7: adcsq_div = 4'd3; // (RL2)
            default: adcsq_div = 4'd1;
        endcase
    endfunction

    function automatic logic [5:0] adcsq_cycles(input logic res10, input logic sh);
        if (sh) begin
            adcsq_cycles = res10 ? CYC_10_SH : CYC_8_SH; // (RL5)
        end else begin
            adcsq_cycles = res10 ? CYC_10_NOSH : CYC_8_NOSH; // (RL4)
        end
    endfunction

endpackage

/* File: design/adcsq_clk_div.sv */
// conversion clock divider: one-cycle tick per conversion clock period
`timescale 1ns/10ps
module adcsq_clk_div (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic [2:0] div_sel, // latched divider select
    output logic tick // one conversion clock edge
);
    import adcsq_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } adcsq_div_st_t;

    adcsq_div_st_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt >= adcsq_div(div_sel) - 4'd1) begin // (RL1)
            st_d.cnt = 4'd0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 4'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule // adcsq_clk_div

/* File: design/adcsq_sar_core.sv */
// successive approximation engine for one channel conversion
`timescale 1ns/10ps
module adcsq_sar_core (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic start, // begin a conversion
    input wire logic abort, // stop at once
    input wire logic tick, // conversion clock edge
    input wire logic res10, // 10-bit resolution
    input wire logic sh, // sample-and-hold in use
    input wire logic cmp_hi, // input above trial level
    output logic busy, // conversion running
    output logic done, // one-cycle completion pulse
    output logic [9:0] code, // result, right aligned
    output logic sample_en, // sampling phase
    output logic [9:0] dac_code // trial level, msb aligned
);
    import adcsq_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic [3:0] bit_idx;
        logic [9:0] sar;
        logic [9:0] code;
    } adcsq_sar_st_t;

    adcsq_sar_st_t st_q, st_d;
    logic [5:0] total;
    logic [5:0] resolve_at;

    always_comb begin
        total = adcsq_cycles(res10, sh);
        resolve_at = total - (res10 ? 6'd10 : 6'd8);
        st_d = st_q;
        st_d.done = 1'b0;
        if (abort) begin
            st_d.busy = 1'b0;
        end else if (start && !st_q.busy) begin
            st_d.busy = 1'b1;
            st_d.cnt = 6'd0;
            st_d.bit_idx = MSB_IDX;
            st_d.sar = 10'h200;
        end else if (st_q.busy && tick) begin
            st_d.cnt = st_q.cnt + 6'd1;
            if (st_q.cnt >= resolve_at) begin // (RL3)
                if (!cmp_hi) begin
                    st_d.sar[st_q.bit_idx] = 1'b0;
                end
                if (st_q.bit_idx != 4'd0) begin
                    st_d.sar[st_q.bit_idx - 4'd1] = 1'b1;
                    st_d.bit_idx = st_q.bit_idx - 4'd1;
                end
            end
            if (st_q.cnt == total - 6'd1) begin // (RL4) (RL5)
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
                st_d.code = res10 ? st_d.sar : {2'b00, st_d.sar[9:2]};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = st_q.busy;
    assign done = st_q.done;
    assign code = st_q.code;
    assign sample_en = st_q.busy && (st_q.cnt < resolve_at);
    assign dac_code = st_q.busy ? st_q.sar : 10'h000;
endmodule // adcsq_sar_core

/* File: design/adcsq_ctrl.sv */
// converter sequencer top: APB registers, trigger, mode sequencing and result store
`timescale 1ns/10ps
module adcsq_ctrl (
    input wire logic sys_clk, // 250 MHz system clock
    input wire logic resetn, // synchronous reset, active low
    input wire adcsq_pkg::adcsq_apb_req_t apb_req, // APB request
    output adcsq_pkg::adcsq_apb_rsp_t apb_rsp, // APB answer
    input wire logic ext_conv_trigger_n, // external trigger pin, falling edge
    input wire logic cmp_hi_pin, // comparator: input above trial level
    output adcsq_pkg::adcsq_afe_t afe, // analogue front end control
    output logic [7:0] timer2_special_ctrl, // protected timer control word
    output logic timer0_trigger_en, // timer 0 as trigger source
    output logic timer1_trigger_en, // timer 1 as trigger source
    output logic irq // level interrupt
);
    import adcsq_pkg::*;

    typedef enum logic [1:0] {
        SEQ_IDLE, SEQ_ARMED, SEQ_CONV, SEQ_NEXT
    } adcsq_seq_t;

    typedef struct packed {
        adcsq_apb_rsp_t rsp;
        logic [2:0] mode;
        logic [2:0] chan;
        logic trigger_source_sel;
        logic conv_start_bit;
        logic [1:0] sweep;
        logic [7:0] ctrl1;
        logic [1:0] trig_en;
        logic protect_write_en;
        logic [7:0] t2sc;
        logic [1:0] status;
        logic [1:0] mask;
        logic [7:0][9:0] result;
        adcsq_seq_t seq;
        logic [2:0] cur;
        logic [2:0] div_sel;
        logic start_pulse;
        logic [2:0] trig_sync;
        logic [1:0] cmp_sync;
        adcsq_afe_t afe;
        logic irq;
    } adcsq_st_t;

    adcsq_st_t st_q, st_d;
    logic tick;
    logic core_busy;
    logic core_done;
    logic [9:0] core_code;
    logic core_sample;
    logic [9:0] core_dac;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] read_word(input adcsq_st_t s, input logic [7:0] a, input logic busy);
        read_word = 32'h0000_0000;
        if (a == ADDR_CTRL0) begin
            read_word = {22'h0, s.sweep, s.conv_start_bit, s.trigger_source_sel, s.chan, s.mode};
        end else if (a == ADDR_CTRL1) begin
            read_word = {24'h0, s.ctrl1};
        end else if (a == ADDR_TRIG) begin
            read_word = {30'h0, s.trig_en};
        end else if (a == ADDR_PROT) begin
            read_word = {30'h0, s.protect_write_en, 1'b0};
        end else if (a == ADDR_T2SC) begin
            read_word = {24'h0, s.t2sc};
        end else if (a == ADDR_STATUS) begin
            read_word = {23'h0, busy, 6'h0, s.status};
        end else if (a == ADDR_MASK) begin
            read_word = {30'h0, s.mask};
        end else if (a >= ADDR_RES0 && a <= ADDR_RES7) begin
            read_word = {22'h0, s.result[a[4:2]]}; // (RL7)
        end
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= ADDR_MASK || (a >= ADDR_RES0 && a <= ADDR_RES7));
    endfunction

    function automatic logic is_sweep(input logic [2:0] m);
        is_sweep = (m != ADCSQ_ONE_SHOT) && (m != ADCSQ_REPEAT);
    endfunction

    function automatic logic is_repeating(input logic [2:0] m);
        is_repeating = (m == ADCSQ_REPEAT) || (m == ADCSQ_REP_SWEEP0) || (m == ADCSQ_REP_SWEEP1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic wr;
    logic rd_setup;
    logic trig_fall;
    logic [2:0] last_ch;
    logic start_now;

    always_comb begin
        st_d = st_q;
        st_d.start_pulse = 1'b0;
        wr = apb_req.psel && apb_req.penable && st_q.rsp.pready && apb_req.pwrite;
        rd_setup = apb_req.psel && !apb_req.penable;
        // pin synchronisers; edge seen between second and third stage
        st_d.trig_sync = {st_q.trig_sync[1:0], ext_conv_trigger_n};
        st_d.cmp_sync = {st_q.cmp_sync[0], cmp_hi_pin};
        trig_fall = st_q.trig_sync[2] && !st_q.trig_sync[1];
        last_ch = {st_q.sweep, 1'b1};
        start_now = 1'b0;

        // bus answer registered one cycle after setup
        st_d.rsp.pready = rd_setup;
        st_d.rsp.pslverr = rd_setup && !mapped(apb_req.paddr);
        st_d.rsp.prdata = (rd_setup && !st_d.rsp.pslverr) ? read_word(st_q, apb_req.paddr, core_busy) : 32'h0000_0000;

        if (wr) begin
            if (apb_req.paddr == ADDR_CTRL0) begin
                st_d.mode = apb_req.pwdata[C0_MODE +: 3];
                st_d.chan = apb_req.pwdata[C0_CHAN +: 3];
                st_d.trigger_source_sel = apb_req.pwdata[C0_TRIG];
                st_d.conv_start_bit = apb_req.pwdata[C0_START];
                st_d.sweep = apb_req.pwdata[C0_SWEEP +: 2];
            end else if (apb_req.paddr == ADDR_CTRL1) begin
                st_d.ctrl1 = apb_req.pwdata[7:0];
            end else if (apb_req.paddr == ADDR_TRIG) begin
                st_d.trig_en = apb_req.pwdata[1:0];
            end else if (apb_req.paddr == ADDR_PROT) begin
                st_d.protect_write_en = apb_req.pwdata[PROT_BIT];
            end else if (apb_req.paddr == ADDR_T2SC) begin
                if (st_q.protect_write_en) begin // (RL12)
                    st_d.t2sc = apb_req.pwdata[7:0];
                end
            end else if (apb_req.paddr == ADDR_STATUS) begin
                st_d.status = st_q.status & ~apb_req.pwdata[1:0];
            end else if (apb_req.paddr == ADDR_MASK) begin
                st_d.mask = apb_req.pwdata[1:0];
            end
        end

        // sequencer
        case (st_q.seq)
            SEQ_IDLE: begin
                if (st_q.conv_start_bit) begin
                    st_d.div_sel = st_q.ctrl1[C1_DIV +: 3]; // (RL2)
                    st_d.cur = is_sweep(st_q.mode) ? 3'd0 : st_q.chan;
                    if (st_q.trigger_source_sel) begin
                        st_d.seq = SEQ_ARMED;
                    end else begin
                        start_now = 1'b1; // (RL13)
                    end
                end
            end
            SEQ_ARMED: begin
                if (trig_fall) begin // (RL13)
                    start_now = 1'b1;
                    st_d.status[ST_TRIG] = 1'b1;
                end
            end
            SEQ_CONV: begin
                if (core_done) begin
                    st_d.result[st_q.cur] = core_code; // (RL7)
                    st_d.seq = SEQ_NEXT;
                end
            end
            SEQ_NEXT: begin
                if (is_sweep(st_q.mode) && st_q.cur != last_ch) begin // (RL6)
                    st_d.cur = st_q.cur + 3'd1;
                    start_now = 1'b1;
                end else if (is_repeating(st_q.mode)) begin // (RL15)
                    st_d.cur = is_sweep(st_q.mode) ? 3'd0 : st_q.chan;
                    start_now = 1'b1;
                end else begin
                    st_d.status[ST_DONE] = 1'b1; // (RL14)
                    st_d.seq = SEQ_IDLE;
                    if (!st_q.trigger_source_sel) begin
                        st_d.conv_start_bit = 1'b0; // (RL14)
                    end else begin
                        st_d.seq = SEQ_ARMED;
                        st_d.cur = is_sweep(st_q.mode) ? 3'd0 : st_q.chan; // (RL6)
                    end
                end
            end
            default: st_d.seq = SEQ_IDLE;
        endcase
        if (start_now) begin
            st_d.seq = SEQ_CONV;
            st_d.start_pulse = 1'b1;
        end
        // clearing the start bit halts everything, including a waiting trigger
        if (!st_d.conv_start_bit) begin // (RL14) (RL15)
            st_d.seq = SEQ_IDLE;
            st_d.start_pulse = 1'b0;
        end

        st_d.afe.sample_en = core_sample;
        st_d.afe.dac_code = core_dac;
        st_d.afe.group = st_q.ctrl1[C1_GROUP +: 2];
        st_d.afe.channel = st_q.cur;
        st_d.afe.ref_connect = st_q.ctrl1[C1_REF]; // (RL8)
        st_d.irq = |(st_q.status & st_q.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.trig_sync <= 3'h7;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // conversion clock and engine

    adcsq_clk_div u_div (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .div_sel(st_q.div_sel),
        .tick(tick)
    );

    adcsq_sar_core u_sar (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(st_q.start_pulse),
        .abort(!st_q.conv_start_bit),
        .tick(tick),
        .res10(st_q.ctrl1[C1_RES10]),
        .sh(st_q.ctrl1[C1_SH]),
        .cmp_hi(st_q.cmp_sync[1]),
        .busy(core_busy),
        .done(core_done),
        .code(core_code),
        .sample_en(core_sample),
        .dac_code(core_dac)
    );

    assign apb_rsp = st_q.rsp;
    assign afe = st_q.afe;
    assign timer2_special_ctrl = st_q.t2sc;
    assign timer0_trigger_en = st_q.trig_en[0];
    assign timer1_trigger_en = st_q.trig_en[1];
    assign irq = st_q.irq;
endmodule // adcsq_ctrl

/* File: testbench/adcsq_ctrl_assertions.sv */
// checker: bus answers, protected word, reference, trial start and interrupt release of the sequencer
`timescale 1ns/10ps
module adcsq_ctrl_assertions (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire adcsq_pkg::adcsq_apb_req_t apb_req, // bus request
    input wire adcsq_pkg::adcsq_apb_rsp_t apb_rsp, // bus answer
    input wire logic ext_conv_trigger_n, // trigger pin
    input wire logic cmp_hi_pin, // comparator
    input wire adcsq_pkg::adcsq_afe_t afe, // front end control
    input wire logic [7:0] timer2_special_ctrl, // protected word
    input wire logic timer0_trigger_en, // timer 0 source
    input wire logic timer1_trigger_en, // timer 1 source
    input wire logic irq // interrupt
);
    import adcsq_pkg::*;
    logic prot_q;
    logic ref_q;
    logic setup;
    logic wr;
    logic mapped;
    logic t2_ok;
    logic clr;
    logic dac_any;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    assign mapped = apb_req.paddr[1:0] == 2'h0
        && (apb_req.paddr <= ADDR_MASK || (apb_req.paddr >= ADDR_RES0 && apb_req.paddr <= ADDR_RES7));
    assign t2_ok = wr && apb_req.paddr == ADDR_T2SC && prot_q;
    assign clr = wr && (apb_req.paddr == ADDR_STATUS || apb_req.paddr == ADDR_MASK);
    assign dac_any = |afe.dac_code;
    // shadow of protect bit and reference bit as software wrote them
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prot_q <= 1'b0;
            ref_q <= 1'b0;
        end else if (wr && apb_req.paddr == ADDR_PROT) begin
            prot_q <= apb_req.pwdata[PROT_BIT];
        end else if (wr && apb_req.paddr == ADDR_CTRL1) begin
            ref_q <= apb_req.pwdata[C1_REF];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        setup;
    endsequence
    sequence s_answer;
        apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence
    a_ready_pulse: assert property (s_setup |=> s_answer)
        else $error("ready not a single cycle after setup");
    a_err_unmapped: assert property (s_setup and !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (s_setup and mapped |=> !apb_rsp.pslverr)
        else $error("mapped access refused");
    a_t2sc_locked: assert property (wr && apb_req.paddr == ADDR_T2SC && !prot_q |=> $stable(timer2_special_ctrl)[*3])
        else $error("protected word changed while locked");
    a_t2sc_source: assert property ($past(resetn) && $changed(timer2_special_ctrl) |-> $past(t2_ok) || $past(t2_ok, 2))
        else $error("protected word changed without enabled write");
    a_ref_follow: assert property (wr && apb_req.paddr == ADDR_CTRL1 |=> ##[0:2] afe.ref_connect == ref_q)
        else $error("reference connect not following control");
    a_trial_msb: assert property ($past(resetn) && $rose(dac_any) |-> afe.dac_code == 10'h200)
        else $error("first trial not at msb");
    a_irq_release: assert property ($past(resetn) && $fell(irq) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
        else $error("interrupt dropped without clear");
endmodule // adcsq_ctrl_assertions

bind adcsq_ctrl adcsq_ctrl_assertions u_chk (.sys_clk(sys_clk), .resetn(resetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .ext_conv_trigger_n(ext_conv_trigger_n), .cmp_hi_pin(cmp_hi_pin), .afe(afe),
    .timer2_special_ctrl(timer2_special_ctrl), .timer0_trigger_en(timer0_trigger_en),
    .timer1_trigger_en(timer1_trigger_en), .irq(irq));

/* File: testbench/adcsq_afe_model.sv */
// comparator model of the analogue front end
`timescale 1ns/10ps
module adcsq_afe_model (
    input wire adcsq_pkg::adcsq_afe_t afe, // trial level and reference state
    input wire logic [9:0] vin, // analogue input as a code
    output logic cmp_hi // input at or above trial level
);
    import adcsq_pkg::*;
    // without the reference the ladder carries nothing, so the comparator reads low
    assign cmp_hi = afe.ref_connect && (vin >= afe.dac_code);
endmodule // adcsq_afe_model

/* File: testbench/adcsq_ctrl_tb.sv */
// testbench: register traffic, conversions, triggers and interrupts of the sequencer
`timescale 1ns/10ps
module adcsq_ctrl_tb;
    import adcsq_pkg::*;
    logic sys_clk;
    logic resetn;
    adcsq_apb_req_t apb_req;
    adcsq_apb_rsp_t apb_rsp;
    logic ext_conv_trigger_n;
    logic cmp_hi;
    adcsq_afe_t afe;
    logic [7:0] t2sc;
    logic t0_en;
    logic t1_en;
    logic irq;
    logic [9:0] vin;
    logic [33:0] exp_q[$];
    int num_errors;
    int comparisons;
    int cycles;
    int dv[8] = '{4, 2, 1, 1, 12, 6, 3, 3};

    adcsq_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .ext_conv_trigger_n(ext_conv_trigger_n), .cmp_hi_pin(cmp_hi), .afe(afe), .timer2_special_ctrl(t2sc),
        .timer0_trigger_en(t0_en), .timer1_trigger_en(t1_en), .irq(irq));
    adcsq_afe_model u_afe (.afe(afe), .vin(vin), .cmp_hi(cmp_hi));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
        exp_q.push_back({err, !w, d});
        @(posedge sys_clk);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: w ? d : 32'h0};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (apb_rsp.pready !== 1'b1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, e, 1'b0);
    endtask
    task automatic wirq(output int t);
        t = 0;
        while (irq !== 1'b1 && t < 2000) begin
            @(posedge sys_clk);
            t++;
        end
    endtask
    function automatic logic [31:0] win(input int t, input int n, input int d);
        return {31'h0, t >= (n - 1) * d && t <= n * d + 12};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin : mon
        logic [33:0] e;
        if (resetn && apb_rsp.pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check({31'h0, apb_rsp.pslverr}, {31'h0, e[33]});
            if (e[32]) begin
                check(apb_rsp.prdata, e[31:0]);
            end
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int t;
        int n;
        resetn = 1'b0;
        apb_req = '0;
        ext_conv_trigger_n = 1'b1;
        vin = 10'h0;
        void'($urandom(32'h33a06b04));
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(ADDR_CTRL1, 32'h0);
        rd(ADDR_T2SC, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, 1'b1);
        apb(1'b0, 8'h02, 32'h0, 1'b1);
        apb(1'b1, 8'h40, 32'h5, 1'b1);
        wr(ADDR_T2SC, 32'ha5);
        rd(ADDR_T2SC, 32'h0);
        wr(ADDR_PROT, 32'h2);
        wr(ADDR_T2SC, 32'h5a);
        rd(ADDR_T2SC, 32'h5a);
        check({24'h0, t2sc}, 32'h5a);
        wr(ADDR_TRIG, 32'h3);
        @(posedge sys_clk);
        check({30'h0, t1_en, t0_en}, 32'h3);
        wr(ADDR_MASK, 32'h3);
        for (int i = 0; i < 8; i++) begin
            vin = 10'($urandom);
            n = i[1] ? (i[0] ? 33 : 28) : (i[0] ? 59 : 49);
            wr(ADDR_CTRL1, {24'h0, 2'($urandom), 1'b1, i[1], i[0], 3'h0});
            wr(ADDR_CTRL0, {24'h0, 2'b10, i[2:0], 3'h0});
            wirq(t);
            check(win(t, n, 4), 32'h1);
            rd(ADDR_STATUS, 32'h1);
            rd(ADDR_CTRL0, {26'h0, i[2:0], 3'h0});
            rd(ADDR_RES0 + 8'(4 * i), i[0] ? {22'h0, vin} : {24'h0, vin[9:2]});
            wr(ADDR_STATUS, 32'h3);
            repeat (3) @(posedge sys_clk);
            check({31'h0, irq}, 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CTRL1, {24'h0, 5'b00110, 3'(i)});
            wr(ADDR_CTRL0, 32'h80);
            wirq(t);
            check(win(t, 28, dv[i]), 32'h1);
            wr(ADDR_STATUS, 32'h1);
        end
        wr(ADDR_CTRL1, 32'h38);
        repeat (2) @(posedge sys_clk);
        check({31'h0, afe.ref_connect}, 32'h1);
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_CTRL0, 32'h80);
        repeat (300) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        rd(ADDR_STATUS, 32'h1);
        wr(ADDR_MASK, 32'h3);
        repeat (3) @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        vin = 10'($urandom);
        wr(ADDR_CTRL0, 32'hd0);
        repeat (300) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        ext_conv_trigger_n <= 1'b0;
        repeat (300) @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        rd(ADDR_STATUS, 32'h3);
        rd(ADDR_CTRL0, 32'hd0);
        rd(ADDR_RES0 + 8'h8, {22'h0, vin});
        check({27'h0, afe.group, afe.channel}, 32'h2);
        ext_conv_trigger_n <= 1'b1;
        wr(ADDR_CTRL0, 32'h0);
        wr(ADDR_STATUS, 32'h3);
        wr(ADDR_CTRL1, 32'h28);
        vin = 10'($urandom);
        wr(ADDR_CTRL0, 32'h99);
        repeat (600) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        rd(ADDR_RES0 + 8'hc, {22'h0, vin});
        vin = 10'($urandom);
        repeat (600) @(posedge sys_clk);
        rd(ADDR_RES0 + 8'hc, {22'h0, vin});
        wr(ADDR_CTRL0, 32'h0);
        repeat (4) @(posedge sys_clk);
        rd(ADDR_STATUS, 32'h0);
        check({22'h0, afe.dac_code}, 32'h0);
        for (int m = 2; m < 8; m++) begin
            vin = 10'($urandom);
            wr(ADDR_CTRL0, {24'h0, 1'b1, m >= 6, 3'h0, 3'(m)});
            if (m >= 6) begin
                ext_conv_trigger_n <= 1'b0;
            end
            repeat (700) @(posedge sys_clk);
            wr(ADDR_CTRL0, 32'h0);
            rd(ADDR_RES0, {22'h0, vin});
            rd(ADDR_RES0 + 8'h4, {22'h0, vin});
            wr(ADDR_STATUS, 32'h3);
            ext_conv_trigger_n <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        wr(ADDR_CTRL1, 32'h0);
        repeat (3) @(posedge sys_clk);
        check({31'h0, afe.ref_connect}, 32'h0);
        summarize();
    end
endmodule // adcsq_ctrl_tb
